/* File: rtl/power_monitor_pkg.sv */
package power_monitor_pkg;

  // Register map, word addresses on the register port.
  localparam logic [3:0] CONFIG_OFFSET = 4'h0;
  localparam logic [3:0] BUS_VOLTAGE_OFFSET = 4'h2;
  localparam logic [3:0] POWER_OFFSET = 4'h3;
  localparam logic [3:0] CURRENT_OFFSET = 4'h4;
  localparam logic [3:0] CALIBRATION_OFFSET = 4'h5;

  // Values after reset.
  localparam logic [15:0] CONFIG_RESET = 16'h2007;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CALIBRATION_RESET = 16'h0000;

  // Configuration fields.
  localparam int CONFIG_RANGE_BIT = 13;
  localparam int CONFIG_MODE_LSB = 0;
  localparam int CONFIG_MODE_W = 3;
  localparam logic [15:0] CONFIG_WRITE_MASK = 16'h2007;

  // Bus voltage register fields.
  localparam int BUS_BITS_LSB = 3;
  localparam int BUS_BITS_W = 13;
  localparam int READY_BIT = 1;
  localparam int OVERFLOW_BIT = 0;

  // Calibration bit 0 never holds a one.
  localparam logic [15:0] CALIBRATION_WRITE_MASK = 16'hfffe;

  // Full-scale counts of the bus voltage, one count per 4 mV.
  localparam logic [12:0] FULL_SCALE_32V = 13'h1f40;
  localparam logic [12:0] FULL_SCALE_16V = 13'h0fa0;

  // Divisor of the power product.
  localparam logic [12:0] POWER_DIV = 13'h1388;

  // Operating modes that stop the converter.
  localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
  localparam logic [2:0] MODE_DISABLE = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CURRENT = 4'b0010,
    ST_POWER = 4'b0100,
    ST_STORE = 4'b1000
  } math_state_t;

endpackage

/* File: rtl/power_monitor_result_registers.sv */
`timescale 1ns/1ps
module power_monitor_result_registers #(
  parameter int CURRENT_SHIFT = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic conv_clk,
  input wire logic conv_rstn,
  input wire logic conv_valid,
  input wire logic [12:0] conv_bus_raw,
  input wire logic [15:0] conv_shunt
);

  // ---------------- Converter clock domain ----------------
  // A new sample is only latched once the previous one was acknowledged,
  // so the held words never change while the register side samples them.
  // Samples that arrive while a transfer is open are dropped; a lost sample
  // is traded against a buffer that the slow conversion rate never needs.
  logic req_tog_r;
  logic ack_meta_r;
  logic ack_sync_r;
  logic [12:0] hold_bus_r;
  logic [15:0] hold_shunt_r;
  logic link_busy;
  logic launch;

  // The acknowledge toggle belongs to the register domain; it is declared here
  // because the converter side synchronises it first.
  logic ack_tog_r;

  assign link_busy = req_tog_r != ack_sync_r;
  assign launch = conv_valid && !link_busy;

  always_ff @(posedge conv_clk) begin
    if (!conv_rstn) begin
      ack_meta_r <= 1'b0;
      ack_sync_r <= 1'b0;
    end else begin
      ack_meta_r <= ack_tog_r;
      ack_sync_r <= ack_meta_r;
    end
  end

  always_ff @(posedge conv_clk) begin
    if (!conv_rstn) begin
      req_tog_r <= 1'b0;
    end else if (launch) begin
      req_tog_r <= ~req_tog_r;
    end
  end

  // The held words change in the same edge as the toggle, at least two register
  // clocks before the register side can see it, so they are settled when read.
  always_ff @(posedge conv_clk) begin
    if (!conv_rstn) begin
      hold_bus_r <= 13'h0000;
      hold_shunt_r <= 16'h0000;
    end else if (launch) begin
      hold_bus_r <= conv_bus_raw;
      hold_shunt_r <= conv_shunt;
    end
  end

  // ---------------- Register clock domain ----------------
  logic req_meta_r;
  logic req_sync_r;
  logic sample_pending;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_meta_r <= 1'b0;
      req_sync_r <= 1'b0;
    end else begin
      req_meta_r <= req_tog_r;
      req_sync_r <= req_meta_r;
    end
  end

  assign sample_pending = req_sync_r != ack_tog_r;

  // Software-visible registers.
  logic [15:0] config_r;
  logic [15:0] calib_r;
  logic [12:0] bus_bits_r;
  logic [15:0] power_r;
  logic [15:0] current_r;
  logic ready_r;
  logic overflow_r;
  logic [15:0] rd_data_r;

  logic [2:0] mode;
  logic range_32v;
  logic converter_on;

  assign mode = config_r[power_monitor_pkg::CONFIG_MODE_LSB +: power_monitor_pkg::CONFIG_MODE_W];
  assign range_32v = config_r[power_monitor_pkg::CONFIG_RANGE_BIT];

  // Power-down and disable stop the converter; every other mode runs it.
  function automatic logic mode_runs(input logic [2:0] m);
    mode_runs = (m != power_monitor_pkg::MODE_POWER_DOWN) &&
                (m != power_monitor_pkg::MODE_DISABLE);
  endfunction

  assign converter_on = mode_runs(mode);

  // Math sequencer working registers.
  power_monitor_pkg::math_state_t state_r;
  logic [15:0] shunt_r;
  logic [12:0] bus_cnt_r;
  logic [15:0] cur_calc_r;
  logic [15:0] pwr_calc_r;
  logic ovf_calc_r;
  logic math_done;

  function automatic logic [12:0] clamp_bus(input logic [12:0] raw, input logic [12:0] full);
    clamp_bus = (raw > full) ? full : raw;
  endfunction

  // Current stage arithmetic.
  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_scaled;
  logic cur_fits;

  assign cur_prod = $signed(shunt_r) * $signed({1'b0, calib_r});
  assign cur_scaled = cur_prod >>> CURRENT_SHIFT;
  assign cur_fits = (cur_scaled[32:15] == {18{1'b0}}) || (cur_scaled[32:15] == {18{1'b1}});

  // Power stage arithmetic on the magnitude of the current.
  logic [16:0] cur_mag;
  logic [29:0] pwr_prod;
  logic [29:0] pwr_quot;

  assign cur_mag = cur_calc_r[15] ? (17'h00000 - {cur_calc_r[15], cur_calc_r})
                                  : {1'b0, cur_calc_r};
  assign pwr_prod = {13'h0000, cur_mag} * {17'h00000, bus_cnt_r};
  assign pwr_quot = pwr_prod / {17'h00000, power_monitor_pkg::POWER_DIV};

  // Every sample seen in idle is acknowledged, also one that a stopped converter
  // discards, so the link never stalls in power-down or disable.
  // A sample that arrives during the math waits in the hold words until idle.
  logic take_sample;
  logic [12:0] bus_full;

  assign take_sample = (state_r == power_monitor_pkg::ST_IDLE) && sample_pending;
  assign bus_full = range_32v ? power_monitor_pkg::FULL_SCALE_32V
                              : power_monitor_pkg::FULL_SCALE_16V;

  // One step per clock, so each product has a full cycle to settle.
  // The divider is the long path; splitting it further would cost latency only.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= power_monitor_pkg::ST_IDLE;
    end else begin
      case (state_r)
        power_monitor_pkg::ST_IDLE: begin
          if (take_sample && converter_on) begin
            state_r <= power_monitor_pkg::ST_CURRENT;
          end
        end
        power_monitor_pkg::ST_CURRENT: begin
          state_r <= power_monitor_pkg::ST_POWER;
        end
        power_monitor_pkg::ST_POWER: begin
          state_r <= power_monitor_pkg::ST_STORE;
        end
        power_monitor_pkg::ST_STORE: begin
          state_r <= power_monitor_pkg::ST_IDLE;
        end
        default: begin
          state_r <= power_monitor_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_tog_r <= 1'b0;
    end else if (take_sample) begin
      ack_tog_r <= req_sync_r;
    end
  end

  // The bus count is clamped on capture, so both stages see the stored value.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shunt_r <= 16'h0000;
      bus_cnt_r <= 13'h0000;
    end else if (take_sample && converter_on) begin
      shunt_r <= hold_shunt_r;
      bus_cnt_r <= clamp_bus(hold_bus_r, bus_full);
    end
  end

  // A current that does not fit saturates rather than wrap.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cur_calc_r <= 16'h0000;
    end else if (state_r == power_monitor_pkg::ST_CURRENT) begin
      if (cur_fits) begin
        cur_calc_r <= cur_scaled[15:0];
      end else begin
        cur_calc_r <= cur_scaled[32] ? 16'h8000 : 16'h7fff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pwr_calc_r <= 16'h0000;
    end else if (state_r == power_monitor_pkg::ST_POWER) begin
      if (pwr_quot[29:16] != 14'h0000) begin
        pwr_calc_r <= 16'hffff;
      end else begin
        pwr_calc_r <= pwr_quot[15:0];
      end
    end
  end

  // The current stage starts the overflow afresh and the power stage may add to
  // it, so the flag never carries over from an earlier conversion.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ovf_calc_r <= 1'b0;
    end else if (state_r == power_monitor_pkg::ST_CURRENT) begin
      ovf_calc_r <= !cur_fits;
    end else if ((state_r == power_monitor_pkg::ST_POWER) &&
                 (pwr_quot[29:16] != 14'h0000)) begin
      ovf_calc_r <= 1'b1;
    end
  end

  assign math_done = state_r == power_monitor_pkg::ST_STORE;

  // Results are all updated in one edge so a read never sees a mixed set.
  // Reads between two completions keep returning the last complete set.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus_bits_r <= power_monitor_pkg::RESULT_RESET[12:0];
    end else if (math_done) begin
      bus_bits_r <= bus_cnt_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      current_r <= power_monitor_pkg::RESULT_RESET;
    end else if (math_done) begin
      current_r <= cur_calc_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      power_r <= power_monitor_pkg::RESULT_RESET;
    end else if (math_done) begin
      power_r <= pwr_calc_r;
    end
  end

  // The overflow flag travels with the words that it qualifies.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      overflow_r <= 1'b0;
    end else if (math_done) begin
      overflow_r <= ovf_calc_r;
    end
  end

  // Conversion-ready: a completion in the same cycle as a clearing access wins.
  logic mode_write;
  logic power_read;

  assign mode_write = wr_en && (addr == power_monitor_pkg::CONFIG_OFFSET) &&
                      mode_runs(wr_data[power_monitor_pkg::CONFIG_MODE_LSB +:
                                        power_monitor_pkg::CONFIG_MODE_W]);
  assign power_read = rd_en && (addr == power_monitor_pkg::POWER_OFFSET);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ready_r <= 1'b0;
    end else if (math_done) begin
      ready_r <= 1'b1;
    end else if (mode_write) begin
      ready_r <= 1'b0;
    end else if (power_read) begin
      ready_r <= 1'b0;
    end
  end

  // Writable registers; result offsets accept no writes.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      config_r <= power_monitor_pkg::CONFIG_RESET;
      calib_r <= power_monitor_pkg::CALIBRATION_RESET;
    end else if (wr_en) begin
      case (addr)
        power_monitor_pkg::CONFIG_OFFSET: begin
          config_r <= wr_data & power_monitor_pkg::CONFIG_WRITE_MASK;
        end
        power_monitor_pkg::CALIBRATION_OFFSET: begin
          calib_r <= wr_data & power_monitor_pkg::CALIBRATION_WRITE_MASK;
        end
        default: begin
          calib_r <= calib_r;
        end
      endcase
    end
  end

  // Read data stand in the cycle after the strobe; unmapped words read zero.
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    case (addr)
      power_monitor_pkg::CONFIG_OFFSET: begin
        rd_mux = config_r;
      end
      power_monitor_pkg::BUS_VOLTAGE_OFFSET: begin
        rd_mux[power_monitor_pkg::BUS_BITS_LSB +: power_monitor_pkg::BUS_BITS_W] = bus_bits_r;
        rd_mux[power_monitor_pkg::READY_BIT] = ready_r;
        rd_mux[power_monitor_pkg::OVERFLOW_BIT] = overflow_r;
      end
      power_monitor_pkg::POWER_OFFSET: begin
        rd_mux = power_r;
      end
      power_monitor_pkg::CURRENT_OFFSET: begin
        rd_mux = current_r;
      end
      power_monitor_pkg::CALIBRATION_OFFSET: begin
        rd_mux = calib_r;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_data_r <= 16'h0000;
    end else if (rd_en) begin
      rd_data_r <= rd_mux;
    end else begin
      rd_data_r <= 16'h0000;
    end
  end

  assign rd_data = rd_data_r;

endmodule

/* File: test/conv_source_model.sv */
`timescale 1ns/1ps
module conv_source_model (
  input wire logic conv_clk,
  output logic conv_valid,
  output logic [12:0] conv_bus_raw,
  output logic [15:0] conv_shunt
);
  initial begin
    conv_valid = 1'b0;
    conv_bus_raw = 13'h0aaa;
    conv_shunt = 16'h5555;
  end
  // Data flip after the strobe, so a late capture shows up as a wrong result.
  task automatic send(input logic [12:0] b, input logic [15:0] s);
    @(posedge conv_clk);
    conv_valid <= 1'b1;
    conv_bus_raw <= b;
    conv_shunt <= s;
    @(posedge conv_clk);
    conv_valid <= 1'b0;
    conv_bus_raw <= ~b;
    conv_shunt <= ~s;
    repeat (8) @(posedge conv_clk);
  endtask
endmodule

/* File: test/power_monitor_result_registers_assertions.sv */
`timescale 1ns/1ps
module power_monitor_result_registers_assertions #(
  parameter int CURRENT_SHIFT = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rd_data,
  input wire logic conv_valid
);
  logic [7:0] quiet_r;
  // A long quiet spell means no completion can set the ready flag mid-check.
  always_ff @(posedge clk) begin
    if (!rstn || conv_valid) quiet_r <= 8'h00;
    else if (quiet_r != 8'hff) quiet_r <= quiet_r + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_reset_zero:
    assert property (disable iff (1'b0) !rstn |=> rd_data == 16'h0000) else $error("reset data");
  a_idle_zero:
    assert property (!rd_en |=> rd_data == 16'h0000) else $error("idle data");
  a_bus_bit2:
    assert property (rd_en && addr == 4'h2 |=> !rd_data[2]) else $error("bus bit2 set");
  a_bus_clamp:
    assert property (rd_en && addr == 4'h2 |=> rd_data[15:3] <= 13'h1f40) else $error("clamp");
  a_unmapped_zero:
    assert property (rd_en && addr > 4'h5 |=> rd_data == 16'h0000) else $error("unmapped");
  a_cal_bit0:
    assert property (rd_en && addr == 4'h5 |=> !rd_data[0]) else $error("cal bit0");
  a_cal_readback:
    assert property (wr_en && addr == 4'h5 ##1 rd_en && addr == 4'h5
      |=> rd_data == ($past(wr_data, 2) & 16'hfffe)) else $error("cal readback");
  a_power_clears:
    assert property (rd_en && addr == 4'h3 && quiet_r > 8'd20 ##1 rd_en && addr == 4'h2
      |=> !rd_data[1]) else $error("ready after power read");
  a_mode_clears:
    assert property (wr_en && addr == 4'h0 && wr_data[2:0] != 3'h0 && wr_data[2:0] != 3'h4
      && quiet_r > 8'd20 ##1 rd_en && addr == 4'h2 |=> !rd_data[1]) else $error("mode");
endmodule

/* File: test/power_monitor_result_registers_bench.sv */
`timescale 1ns/1ps
module power_monitor_result_registers_bench;
  logic clk, rstn, conv_clk, conv_rstn, wr_en, rd_en, conv_valid, pend;
  logic [3:0] addr;
  logic [12:0] conv_bus_raw, b;
  logic [15:0] wr_data, rd_data, conv_shunt, cfg, cal, s;
  logic [15:0] exp_q[$], msk_q[$];
  logic [3:0] adr_q[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int mag;
  power_monitor_result_registers u_power_monitor_result_registers (.clk(clk), .rstn(rstn),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .conv_clk(conv_clk), .conv_rstn(conv_rstn), .conv_valid(conv_valid),
    .conv_bus_raw(conv_bus_raw), .conv_shunt(conv_shunt));
  conv_source_model u_conv_source_model (.conv_clk(conv_clk), .conv_valid(conv_valid),
    .conv_bus_raw(conv_bus_raw), .conv_shunt(conv_shunt));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    conv_clk = 1'b0;
    #7;
    forever #32 conv_clk = ~conv_clk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [3:0] a, input logic [15:0] seen, e, m);
    total_checks++;
    if (((seen ^ e) & m) !== 16'h0000) begin
      n_mismatch++;
      $display("MISMATCH reg %h expected %h seen %h", a, e, seen);
    end
  endtask
  always @(posedge clk) begin
    if (pend && exp_q.size() > 0) check(adr_q.pop_front(), rd_data, exp_q.pop_front(),
      msk_q.pop_front());
    pend = rd_en;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    addr <= a;
    wr_data <= d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    adr_q.push_back(a);
  endtask
  task automatic idle;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  // Mode write first so the poll cannot see the ready flag of an older sample.
  task automatic start(input logic [12:0] bi, input logic [15:0] si);
    int i;
    wr(4'h0, cfg);
    idle();
    u_conv_source_model.send(bi, si);
    for (i = 0; i < 60; i++) begin
      rd(4'h2, 16'h0000, 16'h0000);
      idle();
      #1;
      if (rd_data[1] === 1'b1) break;
    end
    if (i == 60) n_mismatch++;
    if (i == 60) wrap_up();
    repeat (24) @(posedge clk);
  endtask
  task automatic convert(input logic [12:0] bi, eb, input logic [15:0] si, ec, ep, mp,
      input logic ov);
    start(bi, si);
    rd(4'h2, {eb, 2'b01, ov}, 16'hffff);
    rd(4'h4, ec, 16'hffff);
    rd(4'h3, ep, mp);
    rd(4'h2, {eb, 2'b00, ov}, 16'hffff);
    idle();
  endtask
  initial begin
    {rstn, conv_rstn, wr_en, rd_en, pend} = 5'h00;
    addr = 4'h0;
    wr_data = 16'h0000;
    cfg = 16'h2007;
    void'($urandom(32'h0c374394));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge conv_clk) conv_rstn <= 1'b1;
    for (int a = 2; a < 6; a++) rd(a[3:0], 16'h0000, 16'hffff);
    rd(4'hf, 16'h0000, 16'hffff);
    for (int a = 2; a < 5; a++) begin
      wr(a[3:0], 16'($urandom()));
      rd(a[3:0], 16'h0000, 16'hffff);
    end
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      cal = 16'($urandom()) | 16'h0001;
      wr(4'h5, cal);
      rd(4'h5, cal & 16'hfffe, 16'hffff);
    end
    $display("test calibration done");
    wr(4'h5, 16'h1000);
    for (int i = 0; i < 3; i++) begin
      b = 13'($urandom_range(7999));
      mag = $urandom_range(4000);
      s = $urandom_range(1) ? 16'(-mag) : 16'(mag);
      convert(b, b, s, s, 16'(mag * b / 5000), 16'hffff, 1'b0);
    end
    convert(13'h1fff, 13'h1f40, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 1'b0);
    cfg = 16'h0007;
    convert(13'h1f00, 13'h0fa0, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 1'b0);
    cfg = 16'h2007;
    wr(4'h5, 16'h7ffe);
    convert(13'd1000, 13'd1000, 16'h7fff, 16'h7fff, 16'd6553, 16'hffff, 1'b1);
    $display("test conversion done");
    wr(4'h5, 16'h1000);
    for (int m = 0; m < 8; m++) begin
      start(13'd500, 16'h0064);
      wr(4'h0, 16'h2000 | 16'(m));
      rd(4'h2, {13'd500, 1'b0, m == 0 || m == 4, 1'b0}, 16'hffff);
    end
    idle();
    $display("test mode done");
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule
bind power_monitor_result_registers power_monitor_result_registers_assertions
  #(.CURRENT_SHIFT(CURRENT_SHIFT)) u_power_monitor_result_registers_assertions (.clk(clk),
  .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .conv_valid(conv_valid));
